/* File: touch_ctl_pkg.sv */
// Constants and types of the touch converter control logic
// How it works
// - Serial input is ignored until a high start flag is seen.
// - Three bits after start pick channel; with reference bit set the routing.
// - Resolution bit low gives a 12-bit, high an 8-bit next conversion.
// - Reference bit high is single-ended, low is ratiometric across drivers.
// - Code 001 single-ended: x-plus input, Y drivers on, ground to reference.
// - Code 010 single-ended: first auxiliary input, no drivers, external reference.
// - Code 101 single-ended: y-plus input, X drivers on, ground to reference.
// - Code 110 single-ended: second auxiliary input, no drivers, external reference.
// - Code 001 ratiometric: x-plus input, Y drivers on, reference y-plus/y-minus.
// - Code 101 ratiometric: y-plus input, X drivers on, reference x-plus/x-minus.
// - Code 110 ratiometric measures nothing and returns a fixed identity word.
// - Tracking starts on fifth serial clock falling edge after start flag.
// - Acquisition lasts three serial clock cycles; host slows clock if needed.
// - Single-ended mode, unless both power bits are high, switches drivers off once acquisition ends.
// - Ratiometric mode keeps drivers on through acquisition and conversion.
// - Power bits both high keep drivers on and never power down.
// - Fifteen-clock overlapped mode keeps drivers on until told otherwise.
// - Word order: start, three channel bits, mode, reference, power high, low.
// - Control bits taken on first eight rising edges, only after start.
// - After reset the low power bit is 0, the high one 1.
// - New word may start every 15th clock in 12-bit, 11th in 8-bit.
package touch_ctl_pkg;
  localparam int         CW_BITS        = 8;
  localparam int         START_POS      = 7;
  localparam int         CHAN_HI_POS    = 6;
  localparam int         CHAN_MID_POS   = 5;
  localparam int         MODE_POS       = 3;
  localparam int         SER_POS        = 2;
  localparam int         PD_HI_POS      = 1;
  localparam int         PD_LO_POS      = 0;
  localparam logic [7:0] CW_RESET       = 8'h02;
  localparam logic [1:0] PD_RESET       = 2'h2;
  localparam logic [1:0] PD_NO_DOWN     = 2'h3;
  // Serial clock edge numbers counted from the start flag edge
  localparam logic [4:0] RISE_START     = 5'h01;
  localparam logic [4:0] RISE_FIRST_BIT = 5'h02;
  localparam logic [4:0] RISE_CHAN_DONE = 5'h04;
  localparam logic [4:0] RISE_MODE      = 5'h05;
  localparam logic [4:0] RISE_SER       = 5'h06;
  localparam logic [4:0] RISE_LAST_BIT  = 5'h08;
  localparam logic [4:0] FALL_POWER_UP  = 5'h04;
  localparam logic [4:0] FALL_TRACK     = 5'h05;
  localparam logic [4:0] FALL_HOLD      = 5'h08;
  localparam logic [4:0] NEXT_WORD_12   = 5'h0F;
  localparam logic [4:0] NEXT_WORD_8    = 5'h0B;
  localparam int         RES_BITS_12    = 12;
  localparam logic [3:0] RES_CNT_12     = 4'hC;
  localparam logic [3:0] RES_CNT_8      = 4'h8;
  localparam logic [2:0] CH_XP          = 3'h1;
  localparam logic [2:0] CH_AUX1        = 3'h2;
  localparam logic [2:0] CH_YP          = 3'h5;
  localparam logic [2:0] CH_AUX2        = 3'h6;

  typedef enum logic [2:0] {
    MUX_NONE = 3'h0,
    MUX_XP   = 3'h1,
    MUX_AUX1 = 3'h2,
    MUX_YP   = 3'h3,
    MUX_AUX2 = 3'h4
  } mux_sel_t;

  typedef enum logic [1:0] {
    REF_NONE = 2'h0,
    REF_EXT  = 2'h1,
    REF_Y    = 2'h2,
    REF_X    = 2'h3
  } ref_sel_t;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_CTRL = 2'b01,
    ST_CONV = 2'b11
  } state_t;
endpackage : touch_ctl_pkg

/* File: ctrl_bus_if.sv */
// Internal link events and channel decode carrier
`timescale 1ns/1ns
`default_nettype none
interface ctrl_bus_if;
  logic                   rise;
  logic                   fall;
  logic                   cs_act;
  logic                   din;
  logic [2:0]             chan;
  logic                   ser;
  touch_ctl_pkg::mux_sel_t mux;
  logic                   x_drv;
  logic                   y_drv;
  touch_ctl_pkg::ref_sel_t ref_sel;
  logic                   ident;

  modport sync_mp (output rise, fall, cs_act, din);
  modport dec_mp  (input chan, ser,
                   output mux, x_drv, y_drv, ref_sel, ident);
  modport core_mp (input rise, fall, cs_act, din, mux, x_drv, y_drv,
                   ref_sel, ident, output chan, ser);
endinterface : ctrl_bus_if
`default_nettype wire

/* File: link_sync.sv */
// Pin synchronisers and serial clock edge detection
`timescale 1ns/1ns
`default_nettype none
module link_sync (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        serial_conversion_clock_i,
  input  wire logic        cs_n_i,
  input  wire logic        din_i,
  ctrl_bus_if.sync_mp      bus
);
  logic [2:0] clk_q;
  logic [1:0] cs_n_q;
  logic [1:0] din_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      clk_q  <= 3'h0;
      cs_n_q <= 2'h3;
      din_q  <= 2'h0;
    end else begin
      clk_q  <= {clk_q[1:0], serial_conversion_clock_i};
      cs_n_q <= {cs_n_q[0], cs_n_i};
      din_q  <= {din_q[0], din_i};
    end
  end

  // Edges seen only after the second stage
  assign bus.rise   = clk_q[1] & ~clk_q[2];
  assign bus.fall   = ~clk_q[1] & clk_q[2];
  assign bus.cs_act = ~cs_n_q[1];
  assign bus.din    = din_q[1];
endmodule : link_sync
`default_nettype wire

/* File: chan_decode.sv */
// Channel and reference mode routing decode
`timescale 1ns/1ns
`default_nettype none
module chan_decode (
  ctrl_bus_if.dec_mp bus
);
  always_comb begin
    bus.mux     = touch_ctl_pkg::MUX_NONE;
    bus.x_drv   = 1'b0;
    bus.y_drv   = 1'b0;
    bus.ref_sel = touch_ctl_pkg::REF_NONE;
    bus.ident   = 1'b0;
    case ({bus.chan, bus.ser})
      {touch_ctl_pkg::CH_XP, 1'b1}: begin
        bus.mux     = touch_ctl_pkg::MUX_XP;
        bus.y_drv   = 1'b1;
        bus.ref_sel = touch_ctl_pkg::REF_EXT;
      end
      {touch_ctl_pkg::CH_AUX1, 1'b1}: begin
        bus.mux     = touch_ctl_pkg::MUX_AUX1;
        bus.ref_sel = touch_ctl_pkg::REF_EXT;
      end
      {touch_ctl_pkg::CH_YP, 1'b1}: begin
        bus.mux     = touch_ctl_pkg::MUX_YP;
        bus.x_drv   = 1'b1;
        bus.ref_sel = touch_ctl_pkg::REF_EXT;
      end
      {touch_ctl_pkg::CH_AUX2, 1'b1}: begin
        bus.mux     = touch_ctl_pkg::MUX_AUX2;
        bus.ref_sel = touch_ctl_pkg::REF_EXT;
      end
      {touch_ctl_pkg::CH_XP, 1'b0}: begin
        bus.mux     = touch_ctl_pkg::MUX_XP;
        bus.y_drv   = 1'b1;
        bus.ref_sel = touch_ctl_pkg::REF_Y;
      end
      {touch_ctl_pkg::CH_YP, 1'b0}: begin
        bus.mux     = touch_ctl_pkg::MUX_YP;
        bus.x_drv   = 1'b1;
        bus.ref_sel = touch_ctl_pkg::REF_X;
      end
      {touch_ctl_pkg::CH_AUX2, 1'b0}: begin
        bus.ident   = 1'b1;
      end
      default: begin
        bus.mux     = touch_ctl_pkg::MUX_NONE;
      end
    endcase
  end
endmodule : chan_decode
`default_nettype wire

/* File: touch_adc_control_word_decoder.sv */
// Control word capture, routing and conversion sequencing
`timescale 1ns/1ns
`default_nettype none
module touch_adc_control_word_decoder #(
  parameter int          RESULT_W   = 12,
  // Arbitrary value returned for the identity request
  parameter logic [11:0] IDENT_CODE = 12'h5A5
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        serial_conversion_clock_i,
  input  wire logic        cs_n_i,
  input  wire logic        din_i,
  input  wire logic [11:0] conv_result_i,
  output logic             dout_o,
  output logic             dout_oe_n_o,
  output logic             busy_o,
  output logic             busy_oe_n_o,
  output logic [2:0]       mux_sel_o,
  output logic             x_drv_o,
  output logic             y_drv_o,
  output logic [1:0]       ref_sel_o,
  output logic             track_o,
  output logic             res8_o,
  output logic             adc_powered_o,
  output logic [7:0]       control_word_o
);
  generate
    if (RESULT_W != touch_ctl_pkg::RES_BITS_12) begin : g_bad_width
      $error("Result width must be twelve bits");
    end
  endgenerate

  ctrl_bus_if bus ();

  link_sync u_sync (
    .ref_clk_i                 (ref_clk_i),
    .rst_i                     (rst_i),
    .serial_conversion_clock_i (serial_conversion_clock_i),
    .cs_n_i                    (cs_n_i),
    .din_i                     (din_i),
    .bus                       (bus.sync_mp)
  );

  chan_decode u_dec (
    .bus (bus.dec_mp)
  );

  touch_ctl_pkg::state_t state_reg;
  logic [4:0]            cyc_reg;
  logic [4:0]            cyc_next;
  logic [7:0]            conversion_control_word_reg;
  logic [2:0]            chan_reg;
  logic                  ser_reg;
  logic                  res8_reg;
  logic [1:0]            pd_reg;
  logic                  drv_on_reg;
  logic [11:0]           sr_reg;
  logic [3:0]            sr_cnt_reg;
  logic                  conv_end;
  logic                  hold_evt;
  logic                  abort;

  // Bit position in the word for a given rising edge number
  function automatic logic [2:0] bit_index(input logic [4:0] edge_no);
    logic [4:0] pos;
    pos = 5'(touch_ctl_pkg::CW_BITS) - edge_no;
    return pos[2:0];
  endfunction : bit_index

  // Rising edge count after which the next start flag may be heard
  function automatic logic [4:0] next_word_at(input logic res8);
    return res8 ? touch_ctl_pkg::NEXT_WORD_8
                : touch_ctl_pkg::NEXT_WORD_12;
  endfunction : next_word_at

  assign cyc_next = cyc_reg + 5'h01;
  assign abort    = ~bus.cs_act;
  assign hold_evt = bus.fall && state_reg == touch_ctl_pkg::ST_CTRL
                    && cyc_reg == touch_ctl_pkg::FALL_HOLD;
  assign conv_end = bus.fall && !hold_evt && sr_cnt_reg == 4'h1;
  assign bus.chan = chan_reg;
  assign bus.ser  = ser_reg;

  // Word framing and edge counting
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || abort) begin
      state_reg <= touch_ctl_pkg::ST_WAIT;
      cyc_reg   <= 5'h00;
    end else if (bus.rise) begin
      case (state_reg)
        touch_ctl_pkg::ST_WAIT: begin
          if (bus.din) begin
            state_reg <= touch_ctl_pkg::ST_CTRL;
            cyc_reg   <= touch_ctl_pkg::RISE_START;
          end
        end
        touch_ctl_pkg::ST_CTRL: begin
          cyc_reg <= cyc_next;
        end
        touch_ctl_pkg::ST_CONV: begin
          cyc_reg <= cyc_next;
          if (cyc_next == next_word_at(res8_reg)) begin
            state_reg <= touch_ctl_pkg::ST_WAIT;
          end
        end
        default: begin
          state_reg <= touch_ctl_pkg::ST_WAIT;
        end
      endcase
    end else if (hold_evt) begin
      state_reg <= touch_ctl_pkg::ST_CONV;
    end
  end

  // Control word shifted in one bit per rising edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      conversion_control_word_reg <= touch_ctl_pkg::CW_RESET;
    end else if (bus.rise && !abort) begin
      if (state_reg == touch_ctl_pkg::ST_WAIT && bus.din) begin
        conversion_control_word_reg[touch_ctl_pkg::START_POS] <= 1'b1;
      end else if (state_reg == touch_ctl_pkg::ST_CTRL
                   && cyc_next >= touch_ctl_pkg::RISE_FIRST_BIT
                   && cyc_next <= touch_ctl_pkg::RISE_LAST_BIT) begin
        // MSB first: channel, mode, reference, power high, power low
        conversion_control_word_reg[bit_index(cyc_next)] <= bus.din;
      end
    end
  end

  // Fields applied as soon as each one is complete
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      chan_reg <= 3'h0;
      ser_reg  <= 1'b0;
      res8_reg <= 1'b0;
    end else if (bus.rise && !abort
                 && state_reg == touch_ctl_pkg::ST_CTRL) begin
      if (cyc_next == touch_ctl_pkg::RISE_CHAN_DONE) begin
        chan_reg <= {
          conversion_control_word_reg[touch_ctl_pkg::CHAN_HI_POS],
          conversion_control_word_reg[touch_ctl_pkg::CHAN_MID_POS],
          bus.din};
      end
      if (cyc_next == touch_ctl_pkg::RISE_MODE) begin
        res8_reg <= bus.din;
      end
      if (cyc_next == touch_ctl_pkg::RISE_SER) begin
        ser_reg <= bus.din;
      end
    end
  end

  // Power bits take effect when the word completes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pd_reg <= touch_ctl_pkg::PD_RESET;
    end else if (hold_evt) begin
      pd_reg <= conversion_control_word_reg[touch_ctl_pkg::PD_HI_POS:
                                            touch_ctl_pkg::PD_LO_POS];
    end
  end

  // Track window: fifth falling edge to the hold edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || abort) begin
      track_o <= 1'b0;
    end else if (bus.fall && state_reg == touch_ctl_pkg::ST_CTRL) begin
      if (cyc_reg == touch_ctl_pkg::FALL_TRACK) begin
        track_o <= 1'b1;
      end else if (cyc_reg == touch_ctl_pkg::FALL_HOLD) begin
        track_o <= 1'b0;
      end
    end
  end

  // Panel driver enable
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      drv_on_reg <= 1'b0;
    end else if (abort) begin
      if (pd_reg != touch_ctl_pkg::PD_NO_DOWN) begin
        drv_on_reg <= 1'b0;
      end
    end else if (bus.fall && state_reg == touch_ctl_pkg::ST_CTRL
                 && cyc_reg == touch_ctl_pkg::FALL_TRACK) begin
      drv_on_reg <= 1'b1;
    end else if (hold_evt) begin
      // Single-ended may drop the panel once sampled
      if (ser_reg && conversion_control_word_reg[touch_ctl_pkg::PD_HI_POS:
          touch_ctl_pkg::PD_LO_POS] != touch_ctl_pkg::PD_NO_DOWN) begin
        drv_on_reg <= 1'b0;
      end
    end else if (conv_end) begin
      // Ratiometric keeps the panel on until the last result bit
      if (pd_reg != touch_ctl_pkg::PD_NO_DOWN
          && state_reg != touch_ctl_pkg::ST_CTRL) begin
        drv_on_reg <= 1'b0;
      end
    end
  end

  // Converter power
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      adc_powered_o <= 1'b1;
    end else if (bus.fall && state_reg == touch_ctl_pkg::ST_CTRL
                 && cyc_reg == touch_ctl_pkg::FALL_POWER_UP) begin
      adc_powered_o <= 1'b1;
    end else if (conv_end && !pd_reg[1]) begin
      adc_powered_o <= 1'b0;
    end
  end

  // Busy pulse: hold edge to the next falling edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || abort) begin
      busy_o <= 1'b0;
    end else if (hold_evt) begin
      busy_o <= 1'b1;
    end else if (bus.fall) begin
      busy_o <= 1'b0;
    end
  end

  // Result shifter, MSB first on falling edges
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || abort) begin
      sr_reg     <= 12'h000;
      sr_cnt_reg <= 4'h0;
      dout_o     <= 1'b0;
    end else if (hold_evt) begin
      if (bus.ident) begin
        sr_reg <= IDENT_CODE;
      end else begin
        sr_reg <= conv_result_i;
      end
      sr_cnt_reg <= res8_reg ? touch_ctl_pkg::RES_CNT_8
                             : touch_ctl_pkg::RES_CNT_12;
      dout_o     <= 1'b0;
    end else if (bus.fall) begin
      if (sr_cnt_reg != 4'h0) begin
        dout_o     <= sr_reg[11];
        sr_reg     <= {sr_reg[10:0], 1'b0};
        sr_cnt_reg <= sr_cnt_reg - 4'h1;
      end else begin
        dout_o <= 1'b0;
      end
    end
  end

  // Routing outputs follow the decoded fields
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mux_sel_o <= touch_ctl_pkg::MUX_NONE;
      ref_sel_o <= touch_ctl_pkg::REF_NONE;
      x_drv_o   <= 1'b0;
      y_drv_o   <= 1'b0;
    end else begin
      mux_sel_o <= bus.mux;
      ref_sel_o <= bus.ref_sel;
      x_drv_o   <= drv_on_reg & bus.x_drv;
      y_drv_o   <= drv_on_reg & bus.y_drv;
    end
  end

  // Three-state control and status mirrors
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dout_oe_n_o    <= 1'b1;
      busy_oe_n_o    <= 1'b1;
      res8_o         <= 1'b0;
      control_word_o <= touch_ctl_pkg::CW_RESET;
    end else begin
      dout_oe_n_o    <= abort;
      busy_oe_n_o    <= abort;
      res8_o         <= res8_reg;
      control_word_o <= conversion_control_word_reg;
    end
  end
endmodule : touch_adc_control_word_decoder
`default_nettype wire

/* File: touch_adc_control_word_decoder_asserts.sv */
// Port checks for the touch converter control word decoder
`timescale 1ns/1ns
`default_nettype none
module touch_adc_control_word_decoder_asserts (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       cs_n_i,
  input  wire logic       dout_o,
  input  wire logic       dout_oe_n_o,
  input  wire logic       busy_o,
  input  wire logic       busy_oe_n_o,
  input  wire logic [2:0] mux_sel_o,
  input  wire logic       x_drv_o,
  input  wire logic       y_drv_o,
  input  wire logic [1:0] ref_sel_o,
  input  wire logic       track_o,
  input  wire logic       res8_o,
  input  wire logic       adc_powered_o,
  input  wire logic [7:0] control_word_o
);
  localparam logic [2:0] XP = touch_ctl_pkg::MUX_XP;
  localparam logic [2:0] YP = touch_ctl_pkg::MUX_YP;
  logic       ser;
  logic [7:0] trk_cnt;

  assign ser = control_word_o[touch_ctl_pkg::SER_POS];

  // Length of the current tracking phase in system clocks
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !track_o) trk_cnt <= 8'h00;
    else trk_cnt <= trk_cnt + 8'h01;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_oe_with_cs: assert property ($stable(cs_n_i) [*5] |->
    dout_oe_n_o == cs_n_i && busy_oe_n_o == cs_n_i)
    else $error("output enables do not follow chip select");
  a_track_span: assert property (
    $fell(track_o) && busy_o |-> trk_cnt inside {[8'h2D:8'h30]})
    else $error("tracking not three serial periods");
  a_track_bound: assert property (track_o |-> trk_cnt < 8'h31)
    else $error("tracking too long");
  a_dout_quiet: assert property (track_o |-> !dout_o)
    else $error("dout not low during control bits");
  a_res_mode: assert property (
    busy_o |-> res8_o == control_word_o[touch_ctl_pkg::MODE_POS])
    else $error("resolution does not follow mode bit");
  a_se_ref_ext: assert property (
    busy_o && ser && mux_sel_o != 3'h0 |-> ref_sel_o == touch_ctl_pkg::REF_EXT)
    else $error("single-ended reference wrong");
  a_dfr_x_meas: assert property (busy_o && !ser && mux_sel_o == XP |->
    ref_sel_o == touch_ctl_pkg::REF_Y && y_drv_o && !x_drv_o)
    else $error("ratiometric x-plus setup wrong");
  a_dfr_y_meas: assert property (busy_o && !ser && mux_sel_o == YP |->
    ref_sel_o == touch_ctl_pkg::REF_X && x_drv_o && !y_drv_o)
    else $error("ratiometric y-plus setup wrong");
  a_se_drv_off: assert property ($rose(busy_o) && ser &&
    control_word_o[1:0] != touch_ctl_pkg::PD_NO_DOWN |=> !x_drv_o && !y_drv_o)
    else $error("single-ended drivers left on in hold");
  a_drv_match: assert property ($rose(track_o) |=>
    y_drv_o == (mux_sel_o == XP) && x_drv_o == (mux_sel_o == YP))
    else $error("driver switches do not match channel");
  a_pd_keep_on: assert property (
    !adc_powered_o |-> control_word_o[1:0] != touch_ctl_pkg::PD_NO_DOWN)
    else $error("powered down with no-power-down bits");
  a_reset_vals: assert property (
    $fell(rst_i) |-> control_word_o == touch_ctl_pkg::CW_RESET && adc_powered_o)
    else $error("reset values wrong");
endmodule : touch_adc_control_word_decoder_asserts

bind touch_adc_control_word_decoder touch_adc_control_word_decoder_asserts
  touch_adc_control_word_decoder_asserts_inst (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .dout_o(dout_o),
  .dout_oe_n_o(dout_oe_n_o), .busy_o(busy_o), .busy_oe_n_o(busy_oe_n_o),
  .mux_sel_o(mux_sel_o), .x_drv_o(x_drv_o), .y_drv_o(y_drv_o),
  .ref_sel_o(ref_sel_o), .track_o(track_o), .res8_o(res8_o),
  .adc_powered_o(adc_powered_o), .control_word_o(control_word_o));
`default_nettype wire

/* File: serial_host_model.sv */
// Host side of the serial port: sends control words, collects results
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
  output logic        sclk_o,
  output logic        cs_n_o,
  output logic        din_o,
  input  wire logic   dout_i,
  output logic [4:0]  rise_cnt_o,
  output logic [23:0] rx_o
);
  initial begin
    sclk_o     = 1'b0;
    cs_n_o     = 1'b1;
    din_o      = 1'b1;
    rise_cnt_o = 5'h00;
    rx_o       = 24'h000000;
  end

  // Clock stands low between frames
  task automatic frame(input logic [7:0] word, input int lead,
                       input int nclk);
    logic [15:0] bits;
    bits = {word, 8'h00} >> lead;
    rise_cnt_o = 5'h00;
    rx_o = 24'h000000;
    cs_n_o = 1'b0;
    for (int i = 0; i < nclk; i++) begin
      din_o = (i < 16) ? bits[15 - i] : 1'b0;
      #62 sclk_o = 1'b1;
      rx_o = {rx_o[22:0], dout_i};
      rise_cnt_o = rise_cnt_o + 5'h01;
      #63 sclk_o = 1'b0;
    end
    #63 cs_n_o = 1'b1;
    din_o = ~din_o;
    #250;
  endtask : frame
endmodule : serial_host_model
`default_nettype wire

/* File: touch_adc_control_word_decoder_tb.sv */
// Self-checking bench for the touch converter control word decoder
`timescale 1ns/1ns
`default_nettype none
module touch_adc_control_word_decoder_tb;
  localparam logic [11:0] ID_WORD = 12'h3C9;  // Arbitrary identity value
  localparam logic [11:0] SAMPLE  = 12'hA5C;
  logic        ref_clk_i, rst_i;
  logic [11:0] conv_result_i;
  wire logic   sclk, cs_n, din;
  wire logic   dout_o, dout_oe_n_o, busy_o, busy_oe_n_o;
  wire logic   x_drv_o, y_drv_o, track_o, res8_o, adc_powered_o;
  wire logic [2:0]  mux_sel_o;
  wire logic [1:0]  ref_sel_o;
  wire logic [7:0]  control_word_o;
  wire logic [4:0]  rise_cnt;
  wire logic [23:0] rx;
  int          fail_count, n_tests;
  logic [11:0] tbl [8];

  touch_adc_control_word_decoder #(.IDENT_CODE(ID_WORD))
    touch_adc_control_word_decoder_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .serial_conversion_clock_i(sclk),
    .cs_n_i(cs_n), .din_i(din), .conv_result_i(conv_result_i),
    .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .busy_o(busy_o),
    .busy_oe_n_o(busy_oe_n_o), .mux_sel_o(mux_sel_o), .x_drv_o(x_drv_o),
    .y_drv_o(y_drv_o), .ref_sel_o(ref_sel_o), .track_o(track_o),
    .res8_o(res8_o), .adc_powered_o(adc_powered_o),
    .control_word_o(control_word_o));

  serial_host_model serial_host_model_inst (
    .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout_o),
    .rise_cnt_o(rise_cnt), .rx_o(rx));

  task automatic check(input string what, input logic [23:0] exp_v,
                       input logic [23:0] got_v);
    n_tests++;
    if (got_v !== exp_v) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp_v, got_v);
    end
  endtask : check

  task automatic results;
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    #80000;
    fail_count++;
    results();
  end

  initial begin
    logic [7:0]  w;
    logic [11:0] got;
    fail_count = 0;
    n_tests = 0;
    rst_i = 1'b1;
    conv_result_i = SAMPLE;
    // Chan, ref bit, mux, x, y, res8, ref select; ratiometric rows on X/Y and the 110 identity code
    tbl = '{12'h329, 12'h541, 12'hB71, 12'hD81,
            12'h22A, 12'hA73, 12'hC00, 12'h100};
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    check("cw_reset", 24'(touch_ctl_pkg::CW_RESET), 24'(control_word_o));
    serial_host_model_inst.frame(8'h00, 0, 8);
    check("cw_idle", 24'(touch_ctl_pkg::CW_RESET), 24'(control_word_o));
    serial_host_model_inst.frame(8'hE3, 3, 24);
    check("cw_late", 24'h0000E3, 24'(control_word_o));
    check("ident", 24'(ID_WORD), 24'(rx[11:0]));
    check("no_down", 24'h000001, 24'(adc_powered_o));
    for (int i = 0; i < 8; i++) begin
      w = {1'b1, tbl[i][11:9], 1'b0, tbl[i][8], 2'b00};
      fork
        serial_host_model_inst.frame(w, 0, 24);
        begin
          wait (rise_cnt == 5'h05);
          if (!tbl[i][10])
            check("mux_early", 24'(tbl[i][7:5]), 24'(mux_sel_o));
          wait (rise_cnt == 5'h07);
          got = {tbl[i][11:8], mux_sel_o, x_drv_o, y_drv_o, res8_o, ref_sel_o};
          check("route", 24'(tbl[i]), 24'(got));
          check("track", 24'h000001, 24'(track_o));
          wait (rise_cnt == 5'h09);
          got = 12'({x_drv_o, y_drv_o});
          check("hold_drv", tbl[i][8] ? 24'h0 : 24'(tbl[i][4:3]), 24'(got));
        end
      join
      check("result", 24'(i == 6 ? ID_WORD : SAMPLE), 24'(rx[14:3]));
    end
    fork
      serial_host_model_inst.frame(8'h9F, 0, 24);
      begin
        wait (rise_cnt == 5'h07);
        check("res8", 24'h000001, 24'(res8_o));
      end
    join
    check("res8_data", 24'({SAMPLE[11:4], 7'h00}), 24'(rx[14:0]));
    check("keep_on", 24'h000003, 24'({y_drv_o, adc_powered_o}));
    serial_host_model_inst.frame(8'h94, 0, 24);
    check("pwr_down", 24'h000000, 24'({y_drv_o, adc_powered_o}));
    results();
  end
endmodule : touch_adc_control_word_decoder_tb
`default_nettype wire
